// ==== inc/ipu_pkg.sv ====
`default_nettype none
package ipu_pkg;
    // Phase sequence of one instruction cycle.
    typedef enum logic [1:0] {
        PH_ONE,
        PH_TWO,
        PH_THREE,
        PH_FOUR
    } ipu_phase_t;

    // Pointer treatment selected by the alias that the operand touches.
    typedef enum logic [2:0] {
        MODE_PLAIN,
        MODE_POST_DEC,
        MODE_POST_INC,
        MODE_PRE_INC,
        MODE_INDEXED
    } ipu_mode_t;

    // Where the effective address lands.
    typedef enum logic [1:0] {
        KIND_MEM,
        KIND_ALIAS,
        KIND_HALF
    } ipu_kind_t;

    localparam int          ADDR_W          = 12;
    localparam int          NUM_PTR         = 3;
    localparam logic [11:0] PTR_RESET       = 12'h0000;
    localparam logic [11:0] PTR_STEP        = 12'h0001;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;

    // Data addresses of the pointer blocks: block k spans tag, k, offset.
    localparam logic [6:0]  PTR_BLOCK_TAG   = 7'h007C;
    localparam logic [1:0]  PTR_BLOCK_LAST  = 2'h2;
    localparam logic [2:0]  OFS_PLAIN       = 3'h0;
    localparam logic [2:0]  OFS_POST_DEC    = 3'h1;
    localparam logic [2:0]  OFS_POST_INC    = 3'h2;
    localparam logic [2:0]  OFS_PRE_INC     = 3'h3;
    localparam logic [2:0]  OFS_INDEXED     = 3'h4;
    localparam logic [2:0]  OFS_HALF_LOW    = 3'h5;
    localparam logic [2:0]  OFS_HALF_HIGH   = 3'h6;

    // Register port offsets: pointer k low at 2k, high at 2k+1.
    localparam logic [3:0]  REG_PTR0_LOW    = 4'h0;
    localparam logic [3:0]  REG_PTR2_HIGH   = 4'h5;
    localparam logic [3:0]  REG_EA_LOW      = 4'h6;
    localparam logic [3:0]  REG_EA_HIGH     = 4'h7;
endpackage
`default_nettype wire

// ==== src/ipu_pointer_unit.sv ====
// Operation
// R1: An alias operand accesses the memory location held in its pointer, not the alias.
// R2: Three independent 12-bit pointers, each held as high and low byte halves.
// R3: Five aliases per pointer select plain, post-dec, post-inc, pre-inc or indexed.
// R4: Post-dec and post-inc use the current pointer, then step it by one.
// R5: Pre-increment steps the pointer first and uses the stepped value as address.
// R6: Indexed adds the signed accumulator to the pointer; neither is changed.
// R7: Steps act on all 12 bits so low-byte carry or borrow reaches the high byte.
// R8: Pointer steps never touch any status flag, even when the pointer reaches zero.
// R9: An indirect read that lands on an alias returns 00h and sets the zero flag.
// R10: An indirect write that lands on an alias is a no-operation; flags untouched.
// R11: A write into a pointer's own half dominates that pointer's step.
// R12: The operand is read in phase two and the destination written in phase four.
// R13: Indexed sums and pointer updates wrap at 12 bits.
`timescale 1ns/1ps
`default_nettype none
module ipu_pointer_unit (
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 clk_en_in,
    input  wire logic [11:0]          op_addr_in,
    input  wire logic                 op_rd_in,
    input  wire logic                 op_wr_in,
    input  wire logic [7:0]           accumulator_in,
    input  wire logic [7:0]           op_wdata_in,
    input  wire logic [7:0]           mem_rdata_in,
    input  wire logic [3:0]           reg_addr_in,
    input  wire logic [7:0]           reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output var  ipu_pkg::ipu_phase_t  phase_out,
    output logic [11:0]               mem_addr_out,
    output logic                      mem_rd_out,
    output logic                      mem_wr_out,
    output logic [7:0]                mem_wdata_out,
    output logic [7:0]                core_rdata_out,
    output logic                      zero_set_out,
    output logic                      write_nop_out,
    output logic [7:0]                reg_rdata_out
);

    typedef struct packed {
        ipu_pkg::ipu_phase_t ph;
        logic [2:0][11:0]    ptr;
        logic [11:0]         ea;
        ipu_pkg::ipu_kind_t  kind;
        logic                ind;
        logic [1:0]          sel;
        ipu_pkg::ipu_mode_t  mode;
        logic                rd;
        logic                wr;
        logic [7:0]          wdata;
        logic [7:0]          rdata;
        logic                zero_set;
        logic [7:0]          reg_rdata;
    } ipu_state_t;

    ipu_state_t st;
    ipu_state_t next_st;

    function automatic logic blk_hit(input logic [11:0] addr);
        blk_hit = (addr[11:5] == ipu_pkg::PTR_BLOCK_TAG) && (addr[4:3] <= ipu_pkg::PTR_BLOCK_LAST);
    endfunction

    function automatic logic alias_hit(input logic [11:0] addr);
        alias_hit = blk_hit(addr) && (addr[2:0] <= ipu_pkg::OFS_INDEXED);
    endfunction

    function automatic logic half_hit(input logic [11:0] addr);
        half_hit = blk_hit(addr) && ((addr[2:0] == ipu_pkg::OFS_HALF_LOW) ||
                                     (addr[2:0] == ipu_pkg::OFS_HALF_HIGH));
    endfunction

    function automatic ipu_pkg::ipu_mode_t alias_mode(input logic [2:0] ofs);
        case (ofs)
            ipu_pkg::OFS_POST_DEC: alias_mode = ipu_pkg::MODE_POST_DEC;
            ipu_pkg::OFS_POST_INC: alias_mode = ipu_pkg::MODE_POST_INC;
            ipu_pkg::OFS_PRE_INC:  alias_mode = ipu_pkg::MODE_PRE_INC;
            ipu_pkg::OFS_INDEXED:  alias_mode = ipu_pkg::MODE_INDEXED;
            default:               alias_mode = ipu_pkg::MODE_PLAIN;
        endcase
    endfunction

    function automatic logic [11:0] sext_acc(input logic [7:0] acc);
        sext_acc = {{4{acc[7]}}, acc};
    endfunction

    function automatic logic [7:0] half_value(input logic [11:0] ptr, input logic hi);
        half_value = hi ? {4'h0, ptr[11:8]} : ptr[7:0];
    endfunction

    logic [11:0] sel_ptr;
    assign sel_ptr = st.ptr[op_addr_in[4:3]];

    always_comb begin
        next_st = st;
        next_st.zero_set = 1'b0;
        next_st.reg_rdata = ipu_pkg::ZERO_BYTE;
        // Bus writes come first so that a core update of the same pointer in phase four wins.
        if (reg_wr_in && (reg_addr_in <= ipu_pkg::REG_PTR2_HIGH)) begin
            if (reg_addr_in[0]) begin
                next_st.ptr[reg_addr_in[2:1]][11:8] = reg_wdata_in[3:0]; // R2
            end else begin
                next_st.ptr[reg_addr_in[2:1]][7:0] = reg_wdata_in; // R2
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in <= ipu_pkg::REG_PTR2_HIGH) begin
                next_st.reg_rdata = half_value(st.ptr[reg_addr_in[2:1]], reg_addr_in[0]);
            end else if (reg_addr_in == ipu_pkg::REG_EA_LOW) begin
                next_st.reg_rdata = st.ea[7:0];
            end else if (reg_addr_in == ipu_pkg::REG_EA_HIGH) begin
                next_st.reg_rdata = {4'h0, st.ea[11:8]};
            end
        end
        case (st.ph)
            ipu_pkg::PH_ONE: begin
                next_st.ph = ipu_pkg::PH_TWO;
                next_st.rd = op_rd_in;
                next_st.wr = op_wr_in;
                next_st.sel = op_addr_in[4:3];
                if (alias_hit(op_addr_in)) begin
                    // An idle instruction leaves its pointer alone; only an access steps it.
                    next_st.ind = op_rd_in || op_wr_in; // R3
                    next_st.mode = alias_mode(op_addr_in[2:0]); // R3
                    case (alias_mode(op_addr_in[2:0]))
                        ipu_pkg::MODE_PRE_INC: next_st.ea = sel_ptr + ipu_pkg::PTR_STEP; // R5 R13
                        ipu_pkg::MODE_INDEXED:
                            next_st.ea = sel_ptr + sext_acc(accumulator_in); // R6 R13
                        default:               next_st.ea = sel_ptr; // R1 R4
                    endcase
                end else begin
                    next_st.ind = 1'b0;
                    next_st.mode = ipu_pkg::MODE_PLAIN;
                    next_st.ea = op_addr_in;
                end
            end
            ipu_pkg::PH_TWO: begin
                next_st.ph = ipu_pkg::PH_THREE;
                if (st.rd) begin
                    case (st.kind)
                        ipu_pkg::KIND_ALIAS: begin
                            next_st.rdata = ipu_pkg::ZERO_BYTE; // R9
                            next_st.zero_set = 1'b1; // R9
                        end
                        ipu_pkg::KIND_HALF: begin
                            next_st.rdata = half_value(st.ptr[st.ea[4:3]],
                                                       st.ea[2:0] == ipu_pkg::OFS_HALF_HIGH);
                        end
                        default: next_st.rdata = mem_rdata_in; // R12
                    endcase
                end
            end
            ipu_pkg::PH_THREE: begin
                next_st.ph = ipu_pkg::PH_FOUR;
                next_st.wdata = op_wdata_in;
            end
            ipu_pkg::PH_FOUR: begin
                next_st.ph = ipu_pkg::PH_ONE;
                // Steps change only the pointer; no flag output is driven from here.
                if (st.ind) begin
                    case (st.mode)
                        ipu_pkg::MODE_POST_DEC:
                            next_st.ptr[st.sel] = st.ptr[st.sel] - ipu_pkg::PTR_STEP; // R4 R7 R8
                        ipu_pkg::MODE_POST_INC:
                            next_st.ptr[st.sel] = st.ptr[st.sel] + ipu_pkg::PTR_STEP; // R4 R7 R8
                        ipu_pkg::MODE_PRE_INC:
                            next_st.ptr[st.sel] = st.ptr[st.sel] + ipu_pkg::PTR_STEP; // R5 R7
                        // Plain and indexed keep the pointer, so a bus write in this cycle lands.
                        default: ; // R6
                    endcase
                end
                if (st.wr && (st.kind == ipu_pkg::KIND_HALF)) begin
                    if (st.ea[2:0] == ipu_pkg::OFS_HALF_HIGH) begin
                        next_st.ptr[st.ea[4:3]][11:8] = st.wdata[3:0]; // R11
                    end else begin
                        next_st.ptr[st.ea[4:3]][7:0] = st.wdata; // R11
                    end
                end
            end
            default: next_st.ph = ipu_pkg::PH_ONE;
        endcase
        // The landing kind is decoded from the address already chosen in phase one.
        if (st.ph == ipu_pkg::PH_ONE) begin
            if (alias_hit(next_st.ea)) begin
                next_st.kind = ipu_pkg::KIND_ALIAS;
            end else if (half_hit(next_st.ea)) begin
                next_st.kind = ipu_pkg::KIND_HALF;
            end else begin
                next_st.kind = ipu_pkg::KIND_MEM;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
            st.ph <= ipu_pkg::PH_ONE;
            st.ptr <= {ipu_pkg::NUM_PTR{ipu_pkg::PTR_RESET}};
        end else if (clk_en_in) begin
            st <= next_st;
        end
    end

    assign phase_out      = st.ph;
    assign mem_addr_out   = st.ea;
    // Memory strobes are held off for alias and half landings so the memory never sees them.
    assign mem_rd_out     = (st.ph == ipu_pkg::PH_TWO) && st.rd &&
                            (st.kind == ipu_pkg::KIND_MEM); // R12
    assign mem_wr_out     = (st.ph == ipu_pkg::PH_FOUR) && st.wr &&
                            (st.kind == ipu_pkg::KIND_MEM); // R10 R12
    assign write_nop_out  = (st.ph == ipu_pkg::PH_FOUR) && st.wr &&
                            (st.kind == ipu_pkg::KIND_ALIAS); // R10
    assign mem_wdata_out  = st.wdata;
    assign core_rdata_out = st.rdata;
    assign zero_set_out   = st.zero_set;
    assign reg_rdata_out  = st.reg_rdata;

    default clocking dcb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic step_live;
    assign step_live = clk_en_in && (st.ph == ipu_pkg::PH_FOUR) && st.ind &&
                       !(st.wr && (st.kind == ipu_pkg::KIND_HALF) && (st.ea[4:3] == st.sel));

    a_post_inc_step: assert property ( // R4
        step_live && (st.mode == ipu_pkg::MODE_POST_INC)
        |=> st.ptr[$past(st.sel)] == $past(st.ptr[st.sel]) + ipu_pkg::PTR_STEP)
        else $error("post increment did not step pointer by one");
    a_post_dec_wrap: assert property ( // R7
        step_live && (st.mode == ipu_pkg::MODE_POST_DEC) && (st.ptr[st.sel] == 12'h0000)
        |=> st.ptr[$past(st.sel)] == 12'hFFF)
        else $error("post decrement did not borrow through all bits");
    a_pre_inc_addr: assert property ( // R5
        clk_en_in && (st.ph == ipu_pkg::PH_ONE) && alias_hit(op_addr_in)
        && (op_addr_in[2:0] == ipu_pkg::OFS_PRE_INC)
        |=> st.ea == $past(sel_ptr) + ipu_pkg::PTR_STEP)
        else $error("pre increment address is not pointer plus one");
    a_indexed_addr: assert property ( // R13
        clk_en_in && (st.ph == ipu_pkg::PH_ONE) && alias_hit(op_addr_in)
        && (op_addr_in[2:0] == ipu_pkg::OFS_INDEXED)
        |=> st.ea == $past(sel_ptr) + sext_acc($past(accumulator_in)))
        else $error("indexed address is not pointer plus signed accumulator");
    a_indexed_hold: assert property ( // R6
        step_live && (st.mode == ipu_pkg::MODE_INDEXED) && !reg_wr_in
        |=> st.ptr[$past(st.sel)] == $past(st.ptr[st.sel]))
        else $error("indexed access changed a pointer");
    a_alias_read_zero: assert property ( // R9
        clk_en_in && (st.ph == ipu_pkg::PH_TWO) && st.rd && (st.kind == ipu_pkg::KIND_ALIAS)
        |=> (core_rdata_out == ipu_pkg::ZERO_BYTE) && zero_set_out)
        else $error("read through alias did not return zero");
    a_zero_only_alias: assert property ( // R8
        zero_set_out |-> (st.ph == ipu_pkg::PH_THREE) && st.rd && (st.kind == ipu_pkg::KIND_ALIAS))
        else $error("zero flag raised outside an alias read");
    a_alias_write_nop: assert property ( // R10
        (st.ph == ipu_pkg::PH_FOUR) && st.wr && (st.kind == ipu_pkg::KIND_ALIAS)
        |-> !mem_wr_out && write_nop_out)
        else $error("write through alias reached memory");
    a_half_write_wins: assert property ( // R11
        clk_en_in && (st.ph == ipu_pkg::PH_FOUR) && st.wr && (st.kind == ipu_pkg::KIND_HALF)
        && (st.ea[2:0] == ipu_pkg::OFS_HALF_LOW)
        |=> st.ptr[$past(st.ea[4:3])][7:0] == $past(st.wdata))
        else $error("pointer step overrode a write into its half");
    a_strobe_phase: assert property ( // R12
        (mem_rd_out |-> st.ph == ipu_pkg::PH_TWO) and (mem_wr_out |-> st.ph == ipu_pkg::PH_FOUR))
        else $error("memory strobe outside its phase");
    a_plain_addr: assert property ( // R1
        clk_en_in && (st.ph == ipu_pkg::PH_ONE) && alias_hit(op_addr_in)
        && (op_addr_in[2:0] == ipu_pkg::OFS_PLAIN)
        |=> st.ea == $past(sel_ptr))
        else $error("plain alias did not use pointer as address");
    // Without an operand access no pointer may move, whatever address the core shows.
    a_idle_no_step: assert property ( // R3
        clk_en_in && (st.ph == ipu_pkg::PH_FOUR) && !st.rd && !st.wr && !reg_wr_in
        |=> $stable(st.ptr))
        else $error("pointer moved without an operand access");
    a_pre_inc_step: assert property ( // R5
        step_live && (st.mode == ipu_pkg::MODE_PRE_INC)
        |=> st.ptr[$past(st.sel)] == $past(st.ptr[st.sel]) + ipu_pkg::PTR_STEP)
        else $error("pre increment did not leave pointer stepped by one");
    a_post_dec_step: assert property ( // R4
        step_live && (st.mode == ipu_pkg::MODE_POST_DEC)
        |=> st.ptr[$past(st.sel)] == $past(st.ptr[st.sel]) - ipu_pkg::PTR_STEP)
        else $error("post decrement did not step pointer down by one");
    a_half_high_wins: assert property ( // R11
        clk_en_in && (st.ph == ipu_pkg::PH_FOUR) && st.wr && (st.kind == ipu_pkg::KIND_HALF)
        && (st.ea[2:0] == ipu_pkg::OFS_HALF_HIGH)
        |=> st.ptr[$past(st.ea[4:3])][11:8] == $past(st.wdata[3:0]))
        else $error("pointer step overrode a write into its high half");
    a_alias_read_nostrobe: assert property ( // R9
        (st.kind == ipu_pkg::KIND_ALIAS) |-> !mem_rd_out && !mem_wr_out)
        else $error("memory strobe raised for an alias landing");

    c_post_inc: cover property (step_live && (st.mode == ipu_pkg::MODE_POST_INC));
    c_alias_read: cover property (zero_set_out);
    c_half_write: cover property ((st.ph == ipu_pkg::PH_FOUR) && st.wr &&
                                  (st.kind == ipu_pkg::KIND_HALF) && st.ind);
    c_indexed: cover property (step_live && (st.mode == ipu_pkg::MODE_INDEXED));
    c_alias_write: cover property (write_nop_out);

endmodule
`default_nettype wire

// ==== tb/indirect_address_pointer_unit_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module indirect_address_pointer_unit_tb_top;
    logic                ref_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic [11:0]         op_addr = 12'h0000;
    logic                op_rd = 1'b0;
    logic                op_wr = 1'b0;
    logic [7:0]          accumulator = 8'h00;
    logic [7:0]          op_wdata = 8'h00;
    logic [3:0]          reg_addr = 4'h0;
    logic [7:0]          reg_wdata = 8'h00;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic                clk_en = 1'b1;
    ipu_pkg::ipu_phase_t phase;
    logic [11:0]         mem_addr;
    logic                mem_rd, mem_wr, zero_set, write_nop, rds, wrs, zs, wn;
    logic [7:0]          mem_wdata, mem_rdata, core_rdata, reg_rdata, rdat;
    logic [11:0]         ea, p;
    int                  mismatches = 0;
    int                  comparisons = 0;

    ipu_pointer_unit dut_u (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
        .op_addr_in(op_addr), .op_rd_in(op_rd), .op_wr_in(op_wr),
        .accumulator_in(accumulator), .op_wdata_in(op_wdata), .mem_rdata_in(mem_rdata),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .phase_out(phase), .mem_addr_out(mem_addr),
        .mem_rd_out(mem_rd), .mem_wr_out(mem_wr), .mem_wdata_out(mem_wdata),
        .core_rdata_out(core_rdata), .zero_set_out(zero_set),
        .write_nop_out(write_nop), .reg_rdata_out(reg_rdata));

    ipu_mem_model mem_u (.clk_in(ref_clk), .addr_in(mem_addr), .rd_in(mem_rd),
        .wr_in(mem_wr), .wdata_in(mem_wdata), .rdata_out(mem_rdata));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] pat(input logic [11:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic set_ptr(input int k, input logic [11:0] v);
        reg_write(4'(2 * k), v[7:0]);
        reg_write(4'(2 * k + 1), {4'h0, v[11:8]});
    endtask

    task automatic get_ptr(input int k, output logic [11:0] v);
        logic [7:0] lo, hi;
        reg_read(4'(2 * k), lo);
        reg_read(4'(2 * k + 1), hi);
        v = {hi[3:0], lo};
    endtask

    // Aligns to the phase-one cycle, then records the outputs of phases two, three and four.
    task automatic instr(input logic [11:0] a, input logic rd, input logic wr,
                         input logic [7:0] ac, input logic [7:0] wd);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (phase !== ipu_pkg::PH_FOUR && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 8) begin
            mismatches++;
            tally_and_finish();
        end
        @(posedge ref_clk);
        op_addr <= a;
        op_rd <= rd;
        op_wr <= wr;
        accumulator <= ac;
        op_wdata <= wd;
        @(posedge ref_clk);
        op_rd <= 1'b0;
        op_wr <= 1'b0;
        @(negedge ref_clk);
        ea = mem_addr;
        rds = mem_rd;
        @(negedge ref_clk);
        rdat = core_rdata;
        zs = zero_set;
        @(negedge ref_clk);
        wrs = mem_wr;
        wn = write_nop;
    endtask

    task automatic s_regs();
        for (int k = 0; k < 3; k++) begin
            get_ptr(k, p);
            chk("reset ptr", 12'h000, p);
            set_ptr(k, 12'h123 + 12'(k * 12'h333));
        end
        for (int k = 0; k < 3; k++) begin
            get_ptr(k, p);
            chk("ptr readback", 12'h123 + 12'(k * 12'h333), p);
        end
        reg_read(4'h8, rdat);
        chk("unmapped", 12'h000, rdat);
    endtask

    task automatic s_post();
        set_ptr(0, 12'h0FF);
        instr(12'hF82, 1'b1, 1'b0, 8'h00, 8'h00);
        chk("post-inc addr", 12'h0FF, ea);
        chk("read strobe", 12'h001, rds);
        chk("read data", pat(12'h0FF), rdat);
        // The effective address is only held until the next phase one ends.
        reg_read(4'h6, rdat);
        chk("ea low", 12'h0FF, rdat);
        get_ptr(0, p);
        chk("ptr0", 12'h100, p);
        set_ptr(1, 12'h100);
        instr(12'hF89, 1'b0, 1'b1, 8'h00, 8'hC3);
        chk("post-dec addr", 12'h100, ea);
        chk("write strobe", 12'h001, wrs);
        get_ptr(1, p);
        chk("ptr1", 12'h0FF, p);
        chk("memory", 12'h0C3, mem_u.mem[256]);
    endtask

    task automatic s_pre_and_index();
        set_ptr(2, 12'hFFF);
        instr(12'hF93, 1'b1, 1'b0, 8'h00, 8'h00);
        chk("pre-inc addr", 12'h000, ea);
        chk("zero flag", 12'h000, zs);
        get_ptr(2, p);
        chk("ptr2", 12'h000, p);
        set_ptr(0, 12'h001);
        instr(12'hF84, 1'b1, 1'b0, 8'hFD, 8'h00);
        chk("indexed addr", 12'hFFE, ea);
        chk("indexed data", pat(12'hFFE), rdat);
        get_ptr(0, p);
        chk("ptr0 kept", 12'h001, p);
    endtask

    task automatic s_alias_and_half();
        set_ptr(1, 12'hF80);
        instr(12'hF88, 1'b1, 1'b0, 8'h00, 8'h00);
        chk("alias read", 12'h000, rdat);
        chk("zero flag", 12'h001, zs);
        chk("read strobe", 12'h000, rds);
        set_ptr(0, 12'h050);
        set_ptr(1, 12'hF82);
        instr(12'hF88, 1'b0, 1'b1, 8'h00, 8'hAA);
        chk("write nop", 12'h001, wn);
        chk("write strobe", 12'h000, wrs);
        get_ptr(0, p);
        chk("ptr0 kept", 12'h050, p);
        set_ptr(0, 12'hF85);
        instr(12'hF82, 1'b0, 1'b1, 8'h00, 8'h33);
        chk("write strobe", 12'h000, wrs);
        get_ptr(0, p);
        chk("ptr0 half", 12'hF33, p);
        set_ptr(2, 12'hF86);
        instr(12'hF91, 1'b0, 1'b1, 8'h00, 8'h05);
        get_ptr(0, p);
        chk("ptr0 high half", 12'h533, p);
        get_ptr(2, p);
        chk("ptr2 step", 12'hF85, p);
        instr(12'hF91, 1'b1, 1'b0, 8'h00, 8'h00);
        chk("half read", 12'h033, rdat);
        chk("read strobe", 12'h000, rds);
    endtask

    task automatic s_freeze();
        ipu_pkg::ipu_phase_t ph;
        @(posedge ref_clk);
        clk_en <= 1'b0;
        @(negedge ref_clk);
        ph = phase;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("frozen phase", 12'(ph), 12'(phase));
        @(posedge ref_clk);
        clk_en <= 1'b1;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        s_regs();
        s_post();
        s_pre_and_index();
        s_alias_and_half();
        s_freeze();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ==== tb/ipu_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ipu_mem_model (
    input  wire logic        clk_in,
    input  wire logic [11:0] addr_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic [7:0]  wdata_in,
    output logic [7:0]       rdata_out
);
    logic [7:0] mem [4096];
    logic [7:0] idle_q = 8'h00;

    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    // Outside a read the bus toggles every cycle, so stale data cannot pass as a match.
    always @(posedge clk_in) begin
        idle_q <= ~idle_q;
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    assign rdata_out = rd_in ? mem[addr_in] : idle_q;
endmodule
`default_nettype wire
